// *** hdl/enc_trig_pkg.sv ***
package enc_trig_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DROP = 8'h04;
	localparam logic [7:0] OFS_MULT = 8'h08;
	localparam logic [7:0] OFS_LINES = 8'h0C;
	localparam logic [7:0] OFS_INTLINE = 8'h10;
	localparam logic [7:0] OFS_CAMLINE = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int CTRL_ENC_EN = 0;
	localparam int CTRL_DIR_LO = 1;
	localparam int CTRL_SRC_INT = 3;
	localparam int CTRL_AUTO_DLY = 4;
	localparam int CTRL_FAST_EV_EN = 5;
	localparam int CTRL_FT_EN = 6;
	localparam int CTRL_FT_LEVEL_LO = 8;
	localparam int CTRL_FT_DET_LO = 16;
	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] DROP_RST = 16'h0000;
	localparam logic [7:0] MULT_RST = 8'h01;
	localparam logic [23:0] LINES_RST = 24'h00_000A;
	localparam logic [1:0] DIR_IGNORE = 2'h0;
	localparam logic [1:0] DIR_AB = 2'h1;
	localparam logic [1:0] DIR_BA = 2'h2;
	localparam logic [7:0] DET_LOW = 8'h01;
	localparam logic [7:0] DET_HIGH = 8'h02;
	localparam logic [7:0] DET_RISE = 8'h04;
	localparam logic [7:0] DET_FALL = 8'h08;
	localparam logic [7:0] DET_DUAL_RISE = 8'h20;
	localparam logic [7:0] DET_DUAL_FALL = 8'h40;
	localparam logic [1:0] LEVEL_RS422 = 2'h2;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int TRIG_PULSE_NS = 100;
	localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [31:0] PERIOD_MAX = 32'hFFFF_FFFF;
	// ----------------------------------------
	// Frame state
	// ----------------------------------------
	typedef enum logic [2:0] {
		FR_IDLE = 3'b001,
		FR_ARMED = 3'b010,
		FR_STORE = 3'b100
	} frame_state_t;
endpackage

// *** hdl/encoder_line_trigger_vframe.sv ***
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module encoder_line_trigger_vframe #(
	parameter int REV_W = 16 // Reverse counter width
) (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, low active
	input wire logic hsel, // AHB select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic hready, // AHB ready in
	input wire logic [31:0] hwdata, // AHB write data
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB ready out
	output logic hresp, // AHB response
	input wire logic enc_a_opto, // Phase A, opto receiver
	input wire logic enc_b_opto, // Phase B, opto receiver
	input wire logic enc_a_rs422, // Phase A, RS-422 receiver
	input wire logic enc_b_rs422, // Phase B, RS-422 receiver
	input wire logic enc_sel_rs422, // Encoder receiver select
	input wire logic ftrig1_ttl, // Frame trigger 1, single ended receiver
	input wire logic ftrig2_ttl, // Frame trigger 2, single ended receiver
	input wire logic ftrig1_rs422, // Frame trigger 1, RS-422 receiver
	input wire logic ftrig2_rs422, // Frame trigger 2, RS-422 receiver
	input wire logic line_busy, // Camera line in progress
	output logic cam_line_trig, // Camera line trigger
	output logic line_store, // Current line stored in virtual frame
	output logic frame_active // Virtual frame being stored
);
	import enc_trig_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int NSYNC = 10;
	wire [NSYNC-1:0] raw_in = {enc_sel_rs422, line_busy, ftrig2_rs422, ftrig1_rs422, ftrig2_ttl, ftrig1_ttl,
		enc_b_rs422, enc_a_rs422, enc_b_opto, enc_a_opto};
	logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, clean_ff;
	// Three stages; a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					s1_ff[gi] <= 1'b0;
					s2_ff[gi] <= 1'b0;
					s3_ff[gi] <= 1'b0;
					clean_ff[gi] <= 1'b0;
				end else begin
					s1_ff[gi] <= raw_in[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] == s3_ff[gi])
						clean_ff[gi] <= s3_ff[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [31:0] ctrl_ff;
	logic [15:0] drop_ff;
	logic [7:0] mult_ff;
	logic [23:0] lines_ff;
	logic [31:0] intline_ff;
	logic [31:0] camline_ff;
	logic [4:0] stat_ff;
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	wire [1:0] dir_sel = ctrl_ff[CTRL_DIR_LO +: 2];
	wire [7:0] ft_det = ctrl_ff[CTRL_FT_DET_LO +: 8];
	wire [1:0] ft_level = ctrl_ff[CTRL_FT_LEVEL_LO +: 2];
	wire enc_en = ctrl_ff[CTRL_ENC_EN];
	wire ahb_go = hsel && hready && htrans[1];
	wire wr_go = ahb_go && hwrite;
	wire rd_go = ahb_go && !hwrite;
	wire wr_stat = wr_pend_ff && (wr_addr_ff == OFS_STATUS);
	logic [31:0] rd_mux;
	// Read decode; unmapped offsets read zero
	always_comb begin
		unique case (haddr[7:0])
			OFS_CTRL: rd_mux = ctrl_ff;
			OFS_DROP: rd_mux = {16'h0000, drop_ff};
			OFS_MULT: rd_mux = {24'h00_0000, mult_ff};
			OFS_LINES: rd_mux = {8'h00, lines_ff};
			OFS_INTLINE: rd_mux = intline_ff;
			OFS_CAMLINE: rd_mux = camline_ff;
			OFS_STATUS: rd_mux = {27'h000_0000, stat_ff};
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	// Bus phases: zero wait state, OKAY always
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_ff <= wr_go;
			if (wr_go)
				wr_addr_ff <= haddr[7:0];
			if (rd_go)
				hrdata <= rd_mux;
		end
	end
	// Register writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= CTRL_RST;
			drop_ff <= DROP_RST;
			mult_ff <= MULT_RST;
			lines_ff <= LINES_RST;
			intline_ff <= 32'h0000_0000;
			camline_ff <= 32'h0000_0000;
		end else if (wr_pend_ff) begin
			unique case (wr_addr_ff)
				OFS_CTRL: ctrl_ff <= hwdata;
				OFS_DROP: drop_ff <= hwdata[15:0];
				OFS_MULT: mult_ff <= hwdata[7:0];
				OFS_LINES: lines_ff <= hwdata[23:0];
				OFS_INTLINE: intline_ff <= hwdata;
				OFS_CAMLINE: camline_ff <= hwdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Encoder phase select and edges
	// ----------------------------------------
	logic pa_ff, pb_ff;
	wire use_rs422 = clean_ff[9]; // Receiver select is a pin, so it goes through the synchroniser too
	wire pa = use_rs422 ? clean_ff[2] : clean_ff[0];
	wire pb = use_rs422 ? clean_ff[3] : clean_ff[1];
	wire ea = pa ^ pa_ff;
	wire eb = pb ^ pb_ff;
	// Quadrature: step forward for A-then-B when edge sign pattern matches
	wire step_ab = (ea && (pa != pb)) || (eb && (pa == pb));
	wire step_ba = (ea && (pa == pb)) || (eb && (pa != pb));
	wire fwd = (dir_sel == DIR_AB) ? step_ab : step_ba;
	wire bwd = (dir_sel == DIR_AB) ? step_ba : step_ab;
	wire any_edge = ea || eb;

	// ----------------------------------------
	// Direction filter with reverse counter
	// ----------------------------------------
	logic [REV_W-1:0] rev_ff;
	wire rev_full = &rev_ff;
	wire dir_used = (dir_sel == DIR_AB) || (dir_sel == DIR_BA);
	wire cand = enc_en && (dir_used ? (fwd && rev_ff == '0) : any_edge);
	wire rev_ovf = enc_en && dir_used && bwd && rev_full;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pa_ff <= 1'b0;
			pb_ff <= 1'b0;
			rev_ff <= '0;
		end else begin
			pa_ff <= pa;
			pb_ff <= pb;
			if (!enc_en || !dir_used)
				rev_ff <= '0;
			else if (bwd && !rev_full)
				rev_ff <= rev_ff + 1'b1;
			else if (fwd && rev_ff != '0)
				rev_ff <= rev_ff - 1'b1;
		end
	end

	// ----------------------------------------
	// Pulse drop, period measure, multiply
	// ----------------------------------------
	logic [15:0] drop_cnt_ff;
	logic [31:0] per_cnt_ff, period_ff, step_ff, sub_cnt_ff;
	logic [7:0] mul_left_ff;
	wire accept = cand && (drop_cnt_ff == 16'h0000);
	wire [7:0] mult_eff = (mult_ff == 8'h00) ? 8'h01 : mult_ff;
	wire [31:0] step_calc = period_ff / {24'h00_0000, mult_eff};
	wire too_slow = accept && (per_cnt_ff == PERIOD_MAX) && (mult_eff != 8'h01);
	wire sub_fire = (mul_left_ff != 8'h00) && (sub_cnt_ff == 32'h0000_0000);
	wire enc_req = accept || sub_fire;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drop_cnt_ff <= 16'h0000;
			per_cnt_ff <= 32'h0000_0000;
			period_ff <= 32'h0000_0000;
			step_ff <= 32'h0000_0000;
			sub_cnt_ff <= 32'h0000_0000;
			mul_left_ff <= 8'h00;
		end else begin
			if (cand)
				drop_cnt_ff <= (drop_cnt_ff == 16'h0000) ? drop_ff : drop_cnt_ff - 1'b1;
			if (accept) begin
				per_cnt_ff <= 32'h0000_0000;
				period_ff <= per_cnt_ff;
				step_ff <= step_calc;
				sub_cnt_ff <= step_calc;
				mul_left_ff <= mult_eff - 1'b1;
			end else begin
				if (per_cnt_ff != PERIOD_MAX)
					per_cnt_ff <= per_cnt_ff + 1'b1;
				if (sub_fire) begin
					mul_left_ff <= mul_left_ff - 1'b1;
					sub_cnt_ff <= step_ff;
				end else if (sub_cnt_ff != 32'h0000_0000)
					sub_cnt_ff <= sub_cnt_ff - 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Internal line generator and source mux
	// ----------------------------------------
	logic [31:0] int_cnt_ff;
	wire int_req = (intline_ff != 32'h0000_0000) && (int_cnt_ff == 32'h0000_0000);
	wire src_int = ctrl_ff[CTRL_SRC_INT];
	wire req = src_int ? int_req : enc_req;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			int_cnt_ff <= 32'h0000_0000;
		else if (int_req || int_cnt_ff == 32'h0000_0000)
			int_cnt_ff <= intline_ff;
		else
			int_cnt_ff <= int_cnt_ff - 1'b1;
	end

	// ----------------------------------------
	// Auto delay and camera trigger output
	// ----------------------------------------
	logic pend_ff;
	logic [7:0] pulse_ff;
	logic [31:0] guard_ff;
	wire auto_dly = ctrl_ff[CTRL_AUTO_DLY];
	wire cam_busy = clean_ff[8] || (pulse_ff != 8'h00) || (guard_ff != 32'h0000_0000);
	wire want = req || pend_ff;
	wire fire = want && !(auto_dly && cam_busy);
	wire too_fast = auto_dly && req && (pend_ff || cam_busy);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_ff <= 1'b0;
			pulse_ff <= 8'h00;
			guard_ff <= 32'h0000_0000;
			cam_line_trig <= 1'b0;
		end else begin
			pend_ff <= want && !fire;
			if (fire) begin
				pulse_ff <= 8'(TRIG_PULSE_CYC);
				guard_ff <= camline_ff;
			end else begin
				if (pulse_ff != 8'h00)
					pulse_ff <= pulse_ff - 1'b1;
				if (guard_ff != 32'h0000_0000)
					guard_ff <= guard_ff - 1'b1;
			end
			cam_line_trig <= fire || (pulse_ff > 8'h01);
		end
	end

	// ----------------------------------------
	// Frame trigger detection
	// ----------------------------------------
	logic f1_ff, f2_ff, dual_arm_ff;
	wire rs_sel = (ft_level == LEVEL_RS422);
	wire f1 = rs_sel ? clean_ff[6] : clean_ff[4];
	wire f2 = rs_sel ? clean_ff[7] : clean_ff[5];
	wire r1 = f1 && !f1_ff;
	wire d1 = !f1 && f1_ff;
	wire r2 = f2 && !f2_ff;
	wire d2 = !f2 && f2_ff;
	wire ft_hit_raw = (ft_det == DET_LOW && !f1) || (ft_det == DET_HIGH && f1)
		|| (ft_det == DET_RISE && r1) || (ft_det == DET_FALL && d1)
		|| (ft_det == DET_DUAL_RISE && dual_arm_ff && r2)
		|| (ft_det == DET_DUAL_FALL && dual_arm_ff && d2);
	wire ft_hit = ctrl_ff[CTRL_FT_EN] && ft_hit_raw;
	wire dual_start = (ft_det == DET_DUAL_RISE && r1) || (ft_det == DET_DUAL_FALL && d1);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			f1_ff <= 1'b0;
			f2_ff <= 1'b0;
			dual_arm_ff <= 1'b0;
		end else begin
			f1_ff <= f1;
			f2_ff <= f2;
			if (dual_start)
				dual_arm_ff <= 1'b1;
			else if (ft_hit)
				dual_arm_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Virtual frame line gating
	// ----------------------------------------
	frame_state_t fr_ff;
	logic [23:0] line_cnt_ff;
	logic fast_seen_ff;
	wire last_line = (line_cnt_ff + 24'h00_0001 >= lines_ff);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fr_ff <= FR_IDLE;
			line_cnt_ff <= 24'h00_0000;
			line_store <= 1'b0;
			frame_active <= 1'b0;
		end else begin
			line_store <= 1'b0;
			unique case (fr_ff)
				FR_IDLE: if (ft_hit) fr_ff <= FR_ARMED;
				FR_ARMED: if (fire) begin
					line_store <= 1'b1;
					line_cnt_ff <= 24'h00_0001;
					fr_ff <= (lines_ff <= 24'h00_0001) ? FR_IDLE : FR_STORE;
				end
				FR_STORE: if (fire) begin
					line_store <= 1'b1;
					line_cnt_ff <= line_cnt_ff + 24'h00_0001;
					if (last_line)
						fr_ff <= FR_IDLE;
				end
			endcase
			frame_active <= (fr_ff != FR_IDLE);
		end
	end

	// ----------------------------------------
	// Sticky event status, write one to clear
	// ----------------------------------------
	wire fast_ev = too_fast && ctrl_ff[CTRL_FAST_EV_EN] && !fast_seen_ff;
	wire [4:0] ev_set = {fast_ev, too_slow, rev_ovf, ft_hit && fr_ff == FR_IDLE, line_store};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_ff <= 5'h00;
			fast_seen_ff <= 1'b0;
		end else begin
			stat_ff <= ev_set | (stat_ff & ~(wr_stat ? hwdata[4:0] : 5'h00));
			if (fr_ff == FR_IDLE && ft_hit)
				fast_seen_ff <= 1'b0;
			else if (fast_ev)
				fast_seen_ff <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** bench/enc_trig_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module enc_trig_sva
	import enc_trig_pkg::*;
(
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, low active
	input wire logic hsel, // Select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic hready, // Ready in
	input wire logic [31:0] hwdata, // Write data
	input wire logic [31:0] hrdata, // Read data
	input wire logic hreadyout, // Ready out
	input wire logic hresp, // Response
	input wire logic line_busy, // Camera busy
	input wire logic cam_line_trig, // Line trigger
	input wire logic line_store, // Line stored
	input wire logic frame_active // Frame running
);
	logic act_ff, wr_ff;
	logic [7:0] ad_ff;
	logic [31:0] ctrl_ff;
	int busy_ff, off_ff;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Data phase tracking, control shadow and run lengths
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_ff <= 1'b0;
			wr_ff <= 1'b0;
			ad_ff <= 8'h00;
			ctrl_ff <= CTRL_RST;
			busy_ff <= 0;
			off_ff <= 0;
		end else begin
			act_ff <= hsel && hready && htrans[1];
			wr_ff <= hwrite;
			ad_ff <= haddr[7:0];
			if (act_ff && wr_ff && ad_ff == OFS_CTRL)
				ctrl_ff <= hwdata;
			busy_ff <= line_busy ? (busy_ff < 1000 ? busy_ff + 1 : busy_ff) : 0;
			off_ff <= (ctrl_ff[CTRL_ENC_EN] || ctrl_ff[CTRL_SRC_INT]) ? 0 : (off_ff < 1000 ? off_ff + 1 : off_ff);
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
	a_ready_high: assert property (hreadyout == 1'b1) else $error("wait state");
	a_trig_width: assert property ($rose(cam_line_trig) |-> cam_line_trig[*5] ##1 !cam_line_trig)
		else $error("trigger width");
	a_auto_hold: assert property ($rose(cam_line_trig) && ctrl_ff[CTRL_AUTO_DLY] |-> busy_ff < 8)
		else $error("trigger into busy line");
	a_enc_off: assert property ($rose(cam_line_trig) |-> off_ff < 16)
		else $error("trigger while disabled");
	a_rd_unmapped: assert property (act_ff && !wr_ff && ad_ff > OFS_STATUS |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_back: assert property (act_ff && !wr_ff && ad_ff == OFS_CTRL |->
		(hrdata & 32'h00FF_037F) == (ctrl_ff & 32'h00FF_037F)) else $error("control readback");
	a_store_frame: assert property (line_store |-> frame_active)
		else $error("store outside frame");
	a_frame_off: assert property ($rose(frame_active) |-> ctrl_ff[CTRL_FT_EN])
		else $error("frame while disabled");
	c_frame: cover property ($rose(frame_active));
	c_store: cover property (line_store);
	c_busy_trig: cover property ($rose(cam_line_trig) && ctrl_ff[CTRL_AUTO_DLY]);
endmodule
bind encoder_line_trigger_vframe enc_trig_sva chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hwdata, .hrdata, .hreadyout, .hresp, .line_busy, .cam_line_trig, .line_store, .frame_active);
`default_nettype wire

// *** bench/enc_far_side.sv ***
`timescale 1ns/1ns
`default_nettype none
module enc_far_side (
	input wire logic hclk, // Clock
	input wire logic cam_line_trig, // Trigger from the block
	output logic enc_a, // Phase A
	output logic enc_b, // Phase B
	output logic line_busy // Camera line running
);
	int busy_len = 20;
	int left = 0;
	logic trig_q = 1'b0;
	logic [1:0] pos = 2'h0;
	// ----------------------------------------
	// Encoder
	// ----------------------------------------
	// Quadrature count, A leads B when moving forward
	assign enc_a = pos[0] ^ pos[1];
	assign enc_b = pos[1];
	task automatic step(input logic fwd, input int n);
		repeat (n) begin
			pos <= fwd ? pos + 2'h1 : pos - 2'h1;
			repeat (60) @(posedge hclk);
		end
	endtask
	// ----------------------------------------
	// Camera
	// ----------------------------------------
	// A trigger edge while idle starts a line of busy_len cycles
	always @(posedge hclk) begin
		trig_q <= cam_line_trig;
		if (left > 0)
			left <= left - 1;
		else if (cam_line_trig && !trig_q)
			left <= busy_len;
	end
	assign line_busy = left != 0;
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import enc_trig_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic enc_sel_rs422 = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] ft = 4'h0;
	logic [31:0] rd;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp, enc_a, enc_b, line_busy, cam_line_trig, line_store, frame_active;
	int num_errors = 0;
	int n_compared = 0;
	int ntrig = 0;
	int nstore = 0;
	int cyc = 0;
	encoder_line_trigger_vframe #(.REV_W(3)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.enc_a_opto(enc_a & !enc_sel_rs422), .enc_b_opto(enc_b & !enc_sel_rs422),
		.enc_a_rs422(enc_a & enc_sel_rs422), .enc_b_rs422(enc_b & enc_sel_rs422), .enc_sel_rs422,
		.ftrig1_ttl(ft[0]), .ftrig2_ttl(ft[1]), .ftrig1_rs422(ft[2]), .ftrig2_rs422(ft[3]),
		.line_busy, .cam_line_trig, .line_store, .frame_active);
	enc_far_side far (.hclk, .cam_line_trig, .enc_a, .enc_b, .line_busy);
	// Clock, event counters and hang guard
	always #10 hclk = ~hclk;
	always @(posedge cam_line_trig) ntrig = ntrig + 1;
	always @(posedge line_store) nstore = nstore + 1;
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			$display("BAD %0t timeout", $time);
			num_errors = num_errors + 1;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Single bus transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= dat;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		bus(1'b1, a, dat, rd);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, rd);
		chk(rd, exp);
	endtask
	// Settle on four edges, then count triggers over n edges
	task automatic run(input logic fwd, input int n, output int dt);
		int t0;
		far.step(fwd, 4);
		t0 = ntrig;
		far.step(fwd, n);
		dt = ntrig - t0;
	endtask
	initial begin
		logic [7:0] codes [6];
		logic [7:0] cd;
		logic hi, rs;
		int t0, d, b;
		codes = '{DET_LOW, DET_HIGH, DET_RISE, DET_FALL, DET_DUAL_RISE, DET_DUAL_FALL};
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(OFS_CTRL, CTRL_RST);
		rdc(OFS_DROP, {16'h0, DROP_RST});
		rdc(OFS_MULT, {24'h0, MULT_RST});
		rdc(OFS_LINES, {8'h0, LINES_RST});
		rdc(8'h40, 32'h0);
		// Direction ignored: drop and multiply tables
		wr(OFS_CTRL, 32'h1);
		rdc(OFS_CTRL, 32'h1);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_DROP, 32'(i));
			run(1'b1, 12, d);
			chk(32'(d), 32'(12 / (i + 1)));
		end
		wr(OFS_DROP, 32'h0);
		for (int m = 1; m < 4; m++) begin
			wr(OFS_MULT, 32'(m));
			run(1'b1, 4, d);
			chk(32'(d), 32'(4 * m));
		end
		// Drop one of two, then double: twelve edges give twelve triggers
		wr(OFS_DROP, 32'h1);
		wr(OFS_MULT, 32'h2);
		run(1'b1, 12, d);
		chk(32'(d), 32'hC);
		wr(OFS_DROP, 32'h0);
		wr(OFS_MULT, 32'h1);
		enc_sel_rs422 <= 1'b1;
		run(1'b0, 4, d);
		chk(32'(d), 32'h4);
		enc_sel_rs422 <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		run(1'b1, 4, d);
		chk(32'(d), 32'h0);
		// Direction in use: backlash and overflow
		wr(OFS_CTRL, 32'h3);
		run(1'b1, 8, b);
		chk(32'(b), 32'h8);
		t0 = ntrig;
		far.step(1'b0, 6);
		far.step(1'b1, 6);
		chk(32'(ntrig - t0), 32'h0);
		wr(OFS_CTRL, 32'h5);
		run(1'b0, 8, d);
		chk(32'(d), 32'(b));
		wr(OFS_CTRL, 32'h3);
		far.step(1'b0, 40);
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		chk(rd & 32'h4, 32'h4);
		wr(OFS_STATUS, 32'h1F);
		// Slow camera with automatic delay
		far.busy_len <= 150;
		wr(OFS_CTRL, 32'h31);
		run(1'b1, 6, d);
		chk(32'(d > 0 && d < 6), 32'h1);
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		chk(rd & 32'h10, 32'h10);
		far.busy_len <= 20;
		repeat (300) @(posedge hclk);
		// Internal line generator
		wr(OFS_CTRL, 32'h8);
		wr(OFS_INTLINE, 32'h32);
		t0 = ntrig;
		repeat (500) @(posedge hclk);
		chk(32'(ntrig - t0 >= 9 && ntrig - t0 <= 11), 32'h1);
		wr(OFS_INTLINE, 32'h0);
		// Virtual frames for every detection code, then RS-422, then disabled
		wr(OFS_LINES, 32'h3);
		for (int i = 0; i < 8; i++) begin
			cd = (i < 6) ? codes[i] : DET_RISE;
			hi = cd inside {DET_LOW, DET_FALL, DET_DUAL_FALL};
			rs = (i == 6);
			wr(OFS_CTRL, 32'h1);
			ft <= {4{hi}};
			repeat (10) @(posedge hclk);
			wr(OFS_CTRL, {8'h00, cd, 6'h00, rs ? LEVEL_RS422 : 2'h0, i == 7 ? 8'h01 : 8'h41});
			for (int k = 0; k < 2; k++) begin
				ft[2 * rs + k] <= !hi;
				repeat (20) @(posedge hclk);
				ft[2 * rs + k] <= hi;
				repeat (20) @(posedge hclk);
			end
			chk(32'(frame_active), 32'(i != 7));
			t0 = nstore;
			run(1'b1, 6, d);
			chk(32'(nstore - t0), i == 7 ? 32'h0 : 32'h3);
			chk(32'(d), 32'h6);
			chk(32'(frame_active), 32'h0);
		end
		finish_test();
	end
endmodule
`default_nettype wire
